// *** twr_pkg.sv ***
// Function
// - Read data starts right after read header
// - Each further read byte uses advanced pointer
// - Pointer wraps to zero after last register
// - Pointer advances only after byte completes
// - Pointer write, repeated start, then read
// - After repeated start, write header accepted
// - Last pointer value 6Ch, wraps both ways
// - Address 33h when select low, else 36h
package twr_pkg;
    localparam logic [6:0] TWR_DEV_ADDR_LOW = 7'h33;
    localparam logic [6:0] TWR_DEV_ADDR_HIGH = 7'h36;
    localparam logic [6:0] TWR_PTR_LAST = 7'h6c;
    localparam logic [6:0] TWR_PTR_RESET = 7'h00;
    localparam logic [7:0] TWR_DATA_RESET = 8'h00;
    localparam logic [3:0] TWR_ACK_SLOT = 4'h8;
    localparam int TWR_REG_COUNT = 109;

    typedef enum logic [2:0] {
        TWR_IDLE,
        TWR_ADDR,
        TWR_PTR,
        TWR_WDATA,
        TWR_RDATA
    } twr_state_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } twr_write_t;
endpackage : twr_pkg

// *** twr_read_path.sv ***
`timescale 1ns/1ps
module twr_read_path
    import twr_pkg::*;
(
    // System side
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Two-wire link
    input wire logic i_scl_clk,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_sel,
    // Register write events toward the device core
    output logic o_wr_valid,
    output twr_write_t o_wr
);
    // Link domain state.
    logic [1:0] lrst_sync_reg;
    logic [1:0] sel_sync_reg;
    logic start_tog_reg;
    logic stop_tog_reg;
    logic start_ack_reg, start_ack_next;
    logic stop_ack_reg, stop_ack_next;
    twr_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [6:0] ptr_reg, ptr_next;
    logic ok_reg, ok_next;
    logic rw_reg, rw_next;
    logic wr_tog_reg, wr_tog_next;
    twr_write_t wr_word_reg, wr_word_next;
    logic do_write;
    logic oe_reg, oe_next;
    logic [7:0] mem [TWR_REG_COUNT];
    logic link_rst_n;
    logic [6:0] own_addr;
    // System domain state.
    logic [2:0] wr_sync_reg, wr_sync_next;
    logic valid_reg, valid_next;
    twr_write_t out_reg, out_next;

    assign link_rst_n = lrst_sync_reg[1];
    assign own_addr = sel_sync_reg[1] ? TWR_DEV_ADDR_HIGH : TWR_DEV_ADDR_LOW;

    function automatic logic [6:0] advance(input logic [6:0] p);
        return (p == TWR_PTR_LAST) ? TWR_PTR_RESET : 7'(p + 7'h01);
    endfunction : advance

    // A falling SDA while SCL is high marks a start; a rising one marks a stop.
    // These flops run on the data line itself, so they need no link clock edge.
    // Each clears on its own data line edge seen while the link is in reset.
    // The acknowledge side copies them on every link clock edge, so a power-up
    // value never raises a false condition; the clear only gives a known value.
    always_ff @(negedge i_sda_in) begin
        if (!link_rst_n) begin
            start_tog_reg <= 1'b0;
        end else if (i_scl_clk) begin
            start_tog_reg <= ~start_tog_reg;
        end
    end

    always_ff @(posedge i_sda_in) begin
        if (!link_rst_n) begin
            stop_tog_reg <= 1'b0;
        end else if (i_scl_clk) begin
            stop_tog_reg <= ~stop_tog_reg;
        end
    end

    // Reset and the select strap reach the link domain through two flops each.
    always_ff @(posedge i_scl_clk) begin
        lrst_sync_reg <= {lrst_sync_reg[0], i_rst_n};
        sel_sync_reg <= {sel_sync_reg[0], i_addr_sel};
    end

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        ok_next = ok_reg;
        rw_next = rw_reg;
        wr_tog_next = wr_tog_reg;
        wr_word_next = wr_word_reg;
        start_ack_next = start_tog_reg;
        stop_ack_next = stop_tog_reg;
        do_write = 1'b0;
        if (start_tog_reg != start_ack_reg) begin
            // Repeated start keeps the pointer so a combined read follows it.
            st_next = TWR_ADDR;
            // The edge that takes the start also carries the first address bit.
            cnt_next = 4'h1;
            sh_next = {7'h00, i_sda_in};
        end else if (stop_tog_reg != stop_ack_reg) begin
            // The pointer survives a stop, so a plain read resumes after the last access.
            st_next = TWR_IDLE;
            cnt_next = 4'h0;
        end else if (st_reg != TWR_IDLE) begin
            if (cnt_reg != TWR_ACK_SLOT) begin
                sh_next = {sh_reg[6:0], i_sda_in};
                cnt_next = 4'(cnt_reg + 4'h1);
                if (st_reg == TWR_ADDR && cnt_reg == 4'h7) begin
                    ok_next = (sh_reg[6:0] == own_addr);
                    rw_next = i_sda_in;
                end
            end else begin
                cnt_next = 4'h0;
                case (st_reg)
                    TWR_ADDR: begin
                        if (!ok_reg) begin
                            st_next = TWR_IDLE;
                        end else if (rw_reg) begin
                            st_next = TWR_RDATA;
                        end else begin
                            st_next = TWR_PTR;
                        end
                    end
                    TWR_PTR: begin
                        ptr_next = sh_reg[6:0];
                        st_next = TWR_WDATA;
                    end
                    TWR_WDATA: begin
                        do_write = 1'b1;
                        wr_tog_next = ~wr_tog_reg;
                        wr_word_next = '{addr: ptr_reg, data: sh_reg};
                        // A write past the last register skips the store yet still raises a write event; the pointer moves.
                        ptr_next = advance(ptr_reg);
                    end
                    TWR_RDATA: begin
                        // The byte is complete only once the host's ack slot is sampled.
                        ptr_next = advance(ptr_reg);
                        if (i_sda_in) begin
                            st_next = TWR_IDLE;
                        end
                    end
                    default: begin
                        st_next = TWR_IDLE;
                    end
                endcase
            end
        end
        if (!link_rst_n) begin
            st_next = TWR_IDLE;
            cnt_next = 4'h0;
            sh_next = TWR_DATA_RESET;
            ptr_next = TWR_PTR_RESET;
            ok_next = 1'b0;
            rw_next = 1'b0;
            wr_tog_next = 1'b0;
            wr_word_next = '{addr: TWR_PTR_RESET, data: TWR_DATA_RESET};
        end
    end

    always_ff @(posedge i_scl_clk) begin
        st_reg <= st_next;
        cnt_reg <= cnt_next;
        sh_reg <= sh_next;
        ptr_reg <= ptr_next;
        ok_reg <= ok_next;
        rw_reg <= rw_next;
        wr_tog_reg <= wr_tog_next;
        wr_word_reg <= wr_word_next;
        start_ack_reg <= start_ack_next;
        stop_ack_reg <= stop_ack_next;
    end

    // Register store read back by the host; a pointer beyond the last
    // register addresses nothing; the data line is left released, so it reads as FFh.
    always_ff @(posedge i_scl_clk) begin
        if (!link_rst_n) begin
            for (int i = 0; i < TWR_REG_COUNT; i++) begin
                mem[i] <= TWR_DATA_RESET;
            end
        end else if (do_write && ptr_reg <= TWR_PTR_LAST) begin
            mem[ptr_reg] <= sh_reg;
        end
    end

    // SDA changes only while SCL is low, so it is driven from the falling edge.
    always_comb begin
        oe_next = 1'b0;
        if (link_rst_n) begin
            if (cnt_reg == TWR_ACK_SLOT) begin
                // A read byte leaves its ack slot to the host.
                oe_next = (st_reg == TWR_PTR) || (st_reg == TWR_WDATA) ||
                          (st_reg == TWR_ADDR && ok_reg);
            end else if (st_reg == TWR_RDATA && ptr_reg <= TWR_PTR_LAST) begin
                oe_next = ~mem[ptr_reg][3'(4'h7 - cnt_reg)];
            end
        end
    end

    always_ff @(negedge i_scl_clk) begin
        oe_reg <= oe_next;
    end

    assign o_sda_oe = oe_reg;
    assign o_sda_out = 1'b0;

    // Write events cross by toggle; the word is held for a whole byte time,
    // which is far longer than the three system cycles the crossing needs.
    always_comb begin
        wr_sync_next = {wr_sync_reg[1:0], wr_tog_reg};
        valid_next = wr_sync_reg[2] != wr_sync_reg[1];
        out_next = valid_next ? wr_word_reg : out_reg;
        if (!i_rst_n) begin
            wr_sync_next = 3'h0;
            valid_next = 1'b0;
            out_next = '{addr: TWR_PTR_RESET, data: TWR_DATA_RESET};
        end
    end

    always_ff @(posedge i_clock) begin
        wr_sync_reg <= wr_sync_next;
        valid_reg <= valid_next;
        out_reg <= out_next;
    end

    assign o_wr_valid = valid_reg;
    assign o_wr = out_reg;
endmodule : twr_read_path

// *** twr_read_path_checker.sv ***
`timescale 1ns/1ps
module twr_read_path_checker
    import twr_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_wr_valid,
    input wire twr_write_t o_wr
);
    logic [4:0] gap_reg;
    logic [3:0] oe_cnt_reg;
    logic [6:0] last_reg;
    logic [6:0] oe_hist_reg;
    logic burst;
    // Two write events this close together can only be bytes of one burst.
    assign burst = o_wr_valid && gap_reg < 5'h14;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            gap_reg <= 5'h1f;
            oe_cnt_reg <= 4'h0;
            last_reg <= 7'h00;
            oe_hist_reg <= 7'h00;
        end else begin
            gap_reg <= o_wr_valid ? 5'h00 : gap_reg + 5'(gap_reg != 5'h1f);
            oe_cnt_reg <= o_sda_oe ? oe_cnt_reg + 4'h1 : 4'h0;
            last_reg <= o_wr_valid ? o_wr.addr : last_reg;
            oe_hist_reg <= {oe_hist_reg[5:0], o_sda_oe};
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_valid_spaced: assert property (o_wr_valid |=> !o_wr_valid [*8])
        else $error("write events too close");
    a_wr_on_valid: assert property ($changed(o_wr) |-> o_wr_valid)
        else $error("write data moved without event");
    a_wr_in_range: assert property (o_wr_valid |-> o_wr.addr <= TWR_PTR_LAST)
        else $error("write pointer out of range");
    a_ptr_step: assert property (burst && last_reg != TWR_PTR_LAST
        |-> o_wr.addr == last_reg + 7'h01) else $error("pointer did not step");
    a_ptr_wrap: assert property (burst && last_reg == TWR_PTR_LAST
        |-> o_wr.addr == TWR_PTR_RESET) else $error("pointer did not wrap");
    a_ack_write: assert property (o_wr_valid |-> |oe_hist_reg)
        else $error("write event without acknowledge");
    a_oe_release: assert property (oe_cnt_reg != 4'hf)
        else $error("data line held too long");
    a_open_drain: assert property (o_sda_out == 1'b0)
        else $error("data line driven high");
endmodule : twr_read_path_checker
bind twr_read_path twr_read_path_checker u_chk (.i_clock, .i_rst_n, .o_sda_out, .o_sda_oe,
    .o_wr_valid, .o_wr);

// *** twr_host_model.sv ***
`timescale 1ns/1ps
module twr_host_model (
    // Bus lines; the data line has a pull-up, so released reads high.
    output logic o_scl,
    output logic o_pull,
    input wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end
    task automatic idle_clk(input int n);
        repeat (n) begin
            o_scl = 1'b0;
            #15 o_scl = 1'b1;
            #15;
        end
    endtask : idle_clk
    // Also serves as repeated start: SDA is released while SCL is low.
    task automatic start();
        o_pull = 1'b0;
        #7.5 o_scl = 1'b1;
        #7.5 o_pull = 1'b1;
        #7.5 o_scl = 1'b0;
        #7.5;
    endtask : start
    task automatic stop();
        o_pull = 1'b1;
        #7.5 o_scl = 1'b1;
        #7.5 o_pull = 1'b0;
        #15;
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        o_pull = !b;
        #7.5 o_scl = 1'b1;
        #7.5 r = i_sda;
        #7.5 o_scl = 1'b0;
        #7.5;
    endtask : bit_x
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : wbyte
    // The host withholds its acknowledge on the last byte it wants.
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(last, r);
    endtask : rbyte
endmodule : twr_host_model

// *** twr_read_path_tb.sv ***
`timescale 1ns/1ps
module twr_read_path_tb;
    import twr_pkg::*;
    logic i_clock;
    logic i_rst_n;
    logic i_addr_sel;
    logic scl;
    logic pull;
    logic o_sda_out;
    logic o_sda_oe;
    logic o_wr_valid;
    twr_write_t o_wr;
    twr_write_t wr_q[$];
    int n_fail;
    int cmp_count;
    logic [6:0] ptrs [5] = '{7'h6b, 7'h6c, 7'h00, 7'h01, 7'h02};
    wire sda = !pull && !(o_sda_oe && !o_sda_out);
    twr_read_path uut (.i_clock, .i_rst_n, .i_scl_clk(scl), .i_sda_in(sda), .o_sda_out,
        .o_sda_oe, .i_addr_sel, .o_wr_valid, .o_wr);
    twr_host_model host (.o_scl(scl), .o_pull(pull), .i_sda(sda));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = !i_clock;
    end
    always @(negedge i_clock) if (o_wr_valid === 1'b1) wr_q.push_back(o_wr);
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk_val(input string nm, input logic [14:0] e, input logic [14:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val
    task automatic wb(input logic [7:0] d, input logic e);
        logic a;
        host.wbyte(d, a);
        chk_val("ack", {14'h0000, e}, {14'h0000, a});
    endtask : wb
    task automatic rb(input logic last, input logic [7:0] e);
        logic [7:0] d;
        host.rbyte(last, d);
        chk_val("read byte", {7'h00, e}, {7'h00, d});
    endtask : rb
    task automatic ew(input twr_write_t e);
        twr_write_t g;
        g = 'x;
        if (wr_q.size() > 0) g = wr_q.pop_front();
        chk_val("write event", e, g);
    endtask : ew
    task automatic sp();
        host.stop();
        repeat (8) @(posedge i_clock);
    endtask : sp
    task automatic t_write();
        host.start();
        wb(8'h66, 1'b1);
        wb(8'h6b, 1'b1);
        for (int i = 0; i < 5; i++) wb(8'ha1 + 8'(i), 1'b1);
        sp();
        for (int i = 0; i < 5; i++) ew({ptrs[i], 8'ha1 + 8'(i)});
    endtask : t_write
    task automatic t_read();
        host.start();
        wb(8'h66, 1'b1);
        wb(8'h6b, 1'b1);
        host.start();
        wb(8'h67, 1'b1);
        rb(1'b0, 8'ha1);
        rb(1'b0, 8'ha2);
        rb(1'b1, 8'ha3);
        host.stop();
        host.start();
        wb(8'h67, 1'b1);
        rb(1'b0, 8'ha4);
        rb(1'b1, 8'ha5);
        sp();
        chk_val("write count", 15'h0000, 15'(wr_q.size()));
    endtask : t_read
    task automatic t_far();
        host.start();
        wb(8'h66, 1'b1);
        wb(8'h7f, 1'b1);
        host.start();
        wb(8'h67, 1'b1);
        rb(1'b1, 8'hff);
        sp();
    endtask : t_far
    task automatic t_sr_write();
        host.start();
        wb(8'h66, 1'b1);
        wb(8'h10, 1'b1);
        host.start();
        wb(8'h66, 1'b1);
        wb(8'h20, 1'b1);
        wb(8'h55, 1'b1);
        sp();
        ew({7'h20, 8'h55});
    endtask : t_sr_write
    task automatic t_sel();
        host.start();
        wb(8'h6c, 1'b0);
        host.stop();
        @(posedge i_clock) i_addr_sel <= 1'b1;
        host.idle_clk(3);
        host.start();
        wb(8'h6c, 1'b1);
        wb(8'h05, 1'b1);
        wb(8'h77, 1'b1);
        sp();
        ew({7'h05, 8'h77});
        host.start();
        wb(8'h66, 1'b0);
        host.stop();
    endtask : t_sel
    initial begin
        #60000;
        n_fail++;
        finish_test();
    end
    initial begin
        i_rst_n = 1'b0;
        i_addr_sel = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        fork
            begin
                host.idle_clk(4);
                // A start and a stop during reset clear the data line edge flops.
                host.stop();
            end
            repeat (6) @(posedge i_clock);
        join
        i_rst_n <= 1'b1;
        host.idle_clk(3);
        t_write();
        t_read();
        t_far();
        t_sr_write();
        t_sel();
        finish_test();
    end
endmodule : twr_read_path_tb
